// File: verilog/vmc_mode_load.sv
// Mode load, reset and option decode of the video RAM controller.
// Assumes host pins synchronous to clk_i and an outside refresh engine.
`timescale 1ns/1ps
module vmc_mode_load
   import vmc_pkg::*;
#(
   parameter int unsigned INIT_CYCLES_P = INIT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire vmc_host_t host_i,
   input wire logic portb_access_request_n_i,
   input wire logic portb_grant_i,
   input wire logic refresh_busy_i,
   input wire logic refresh_req_i,
   input wire logic scrub_refresh_i,
   input wire logic refresh_row_i,
   input wire logic shift_load_request_i,
   output logic row_strobe_out_n_o,
   output logic [NCAS-1:0] col_strobe_out_n_o,
   output logic refresh_status_n_o,
   output logic transfer_output_enable_n_o,
   output logic wait_n_o,
   output logic [ADDR_W-1:0] latched_addr_o,
   output logic [PROG_W-1:0] prog_word_o,
   output vmc_opts_t opts_o,
   output logic programmed_o,
   output logic init_active_o
);

   // Pulls option fields out of a programming word
   function automatic vmc_opts_t decode_opts(input logic [PROG_W-1:0] w);
      vmc_opts_t o;
      o.cas_extend = w[POS_CAS_EXTEND];
      o.latch_mode_bit = w[POS_LATCH_MODE];
      o.access_mode_bit = w[POS_ACCESS_MODE];
      o.write_cas_delay_bit = w[POS_WRITE_CAS_DELAY];
      return o;
   endfunction

   // Edge history of host strobes
   logic ml_prev_q; // Mode load last cycle
   logic access_request_n_prev_q; // Access request last cycle
   logic slr_prev_q; // Shift load request last cycle
   // Programming state
   logic [PROG_W-1:0] prog_q; // Programming register
   logic programmed_q; // At least one programming done
   logic first_pend_q; // Next programming is the first
   logic cs_done_q; // Chip-selected programming in this window
   // Initialization and precharge
   logic [INIT_CNT_W-1:0] init_cnt_q; // Init cycles left
   logic [PRE_CNT_W-1:0] pre_cnt_q; // Precharge cycles left
   // Access machine
   vmc_ac_state_t ac_q; // Current access state
   vmc_ac_state_t ac_d; // Next access state
   logic row_n_q; // Row strobe flop
   logic [NCAS-1:0] col_n_q; // Column strobe flops
   logic wait_n_q; // Wait flop
   logic dt_n_q; // Transfer enable flop
   logic [DT_CNT_W-1:0] dt_cnt_q; // Edges since load request
   logic rfs_n_q; // Refresh status flop
   logic [ADDR_W-1:0] addr_q; // Address latch
   // Decoded and combinational
   vmc_opts_t opt; // Options in force
   logic seq_busy; // Reset sequence owns mode load
   logic seq_rst; // Reset state entered this edge
   logic seq_prog; // Reset sequence programs
   logic ml_rise; // Mode load released
   logic cs_prog; // Chip-selected programming event
   logic plain_prog; // Release-only programming event
   logic prog_ev; // Any programming event
   logic [PROG_W-1:0] word_in; // Word on the pins
   logic strobe_ok; // Port A strobes honoured
   logic start_a; // Port A access start
   logic ready; // Init over and precharge met
   logic latch_hit; // Address capture condition

   assign opt = decode_opts(prog_q);
   assign word_in = {host_i.addr, host_i.cas_extend_in_n[0]};

   // Reset and release-order detector
   vmc_reset_seq u_seq (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .mode_load_n_i(host_i.mode_load_n),
      .refresh_disable_n_i(host_i.refresh_disable_n),
      .busy_o(seq_busy),
      .ext_reset_o(seq_rst),
      .program_o(seq_prog)
   );

   // Programming events; the host glue shapes mode load itself
   assign ml_rise = host_i.mode_load_n & ~ml_prev_q;
   // Access request falling under mode load and chip select
   assign cs_prog = ~host_i.mode_load_n & ~host_i.chip_sel_n &
      ~host_i.access_request_n & access_request_n_prev_q;
   // Release after a chip-selected program keeps that word
   assign plain_prog = ml_rise & ~seq_busy & ~cs_done_q;
   assign prog_ev = plain_prog | seq_prog | cs_prog;

   // Strobes are dead while mode load is asserted or unprogrammed
   assign strobe_ok = host_i.mode_load_n & programmed_q;
   // Start source depends on the access mode bit
   assign start_a = strobe_ok & (opt.access_mode_bit ?
      ~host_i.addr_strobe_n : host_i.ale);
   assign ready = (init_cnt_q == '0) & (pre_cnt_q == '0);
   assign latch_hit = (strobe_ok & (~host_i.addr_strobe_n | host_i.ale)) |
      (~portb_access_request_n_i & portb_grant_i);

   // Strobe history; mode load idles released
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ml_prev_q <= 1'b1;
         access_request_n_prev_q <= 1'b1;
         slr_prev_q <= 1'b0;
      end else begin
         ml_prev_q <= host_i.mode_load_n;
         access_request_n_prev_q <= host_i.access_request_n;
         slr_prev_q <= shift_load_request_i;
      end
   end

   // Programming register, loaded on any qualifying event
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prog_q <= PROG_RESET;
      end else if (seq_rst) begin
         prog_q <= PROG_RESET;
      end else if (prog_ev) begin
         // Captured here, in force from the next edge
         prog_q <= word_in;
      end
   end

   // Programmed flag and chip-selected window marker
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         programmed_q <= 1'b0;
         cs_done_q <= 1'b0;
      end else if (seq_rst) begin
         programmed_q <= 1'b0;
         cs_done_q <= 1'b0;
      end else begin
         if (prog_ev) begin
            programmed_q <= 1'b1;
         end
         // Window closes with the mode load release
         if (cs_prog) begin
            cs_done_q <= 1'b1;
         end else if (ml_rise) begin
            cs_done_q <= 1'b0;
         end
      end
   end

   // First-programming marker; rearmed by either reset
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         first_pend_q <= 1'b1;
      end else if (seq_rst) begin
         first_pend_q <= 1'b1;
      end else if (prog_ev) begin
         first_pend_q <= 1'b0;
      end
   end

   // Initialization period; the long count is a parameter
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         init_cnt_q <= '0;
      end else if (seq_rst) begin
         init_cnt_q <= '0;
      end else if (prog_ev && first_pend_q) begin
         init_cnt_q <= INIT_CNT_W'(INIT_CYCLES_P);
      end else if (init_cnt_q != '0) begin
         init_cnt_q <= init_cnt_q - INIT_CNT_W'(1);
      end
   end

   // Precharge after init end and after each access row strobe
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pre_cnt_q <= '0;
      end else if (seq_rst) begin
         pre_cnt_q <= '0;
      end else if (init_cnt_q == INIT_CNT_W'(1)) begin
         pre_cnt_q <= PRE_CNT_W'(PRECHARGE_CYCLES);
      end else if (ac_q == AC_ROW && ac_d != AC_ROW) begin
         pre_cnt_q <= PRE_CNT_W'(PRECHARGE_CYCLES);
      end else if (pre_cnt_q != '0) begin
         pre_cnt_q <= pre_cnt_q - PRE_CNT_W'(1);
      end
   end

   // Next access state
   always_comb begin
      ac_d = ac_q;
      case (ac_q)
         AC_IDLE: begin
            // Start only with the request active
            if (start_a && !host_i.access_request_n) begin
               ac_d = ready ? AC_ROW : AC_PEND;
            end
         end
         AC_PEND: begin
            // Held by wait states until ready
            if (host_i.access_request_n) begin
               ac_d = AC_IDLE;
            end else if (ready) begin
               ac_d = AC_ROW;
            end
         end
         AC_ROW: begin
            // Released request ends the access
            if (host_i.access_request_n) begin
               ac_d = AC_IDLE;
            end
         end
         default: begin
            ac_d = AC_IDLE;
         end
      endcase
   end

   // Access state register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ac_q <= AC_IDLE;
      end else if (seq_rst) begin
         ac_q <= AC_IDLE;
      end else begin
         ac_q <= ac_d;
      end
   end

   // Row strobe covers accesses and outside refreshes
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         row_n_q <= 1'b1;
      end else begin
         row_n_q <= ~((ac_d == AC_ROW) | refresh_row_i);
      end
   end

   // Wait states while a request is pending
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wait_n_q <= 1'b1;
      end else begin
         wait_n_q <= ~(ac_d == AC_PEND);
      end
   end

   // Column strobes, one per extend input
   genvar gi;
   generate
      for (gi = 0; gi < NCAS; gi++) begin : g_col
         logic on_d; // Strobe wanted next cycle
         always_comb begin
            if (scrub_refresh_i) begin
               // Scrubbing ignores extend inputs and option
               on_d = refresh_row_i;
            end else if (opt.cas_extend) begin
               // May outlast the row strobe
               on_d = ~host_i.cas_extend_in_n[gi] &
                  ((ac_d == AC_ROW && ac_q == AC_ROW) | ~col_n_q[gi]);
            end else begin
               // Drops with the row when request ends
               on_d = ~host_i.cas_extend_in_n[gi] &
                  (ac_d == AC_ROW) & (ac_q == AC_ROW);
            end
         end
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               col_n_q[gi] <= 1'b1;
            end else begin
               col_n_q[gi] <= ~on_d;
            end
         end
      end
   endgenerate

   // Shared refresh status pin
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rfs_n_q <= 1'b1;
      end else if (opt.cas_extend) begin
         rfs_n_q <= ~refresh_req_i;
      end else begin
         // Held active through initialization too
         rfs_n_q <= ~(refresh_busy_i | (init_cnt_q != '0));
      end
   end

   // Transfer enable during a shift-register load
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dt_n_q <= 1'b1;
         dt_cnt_q <= '0;
      end else if (shift_load_request_i && !slr_prev_q) begin
         // Request seen: first edge of the count
         dt_n_q <= 1'b0;
         dt_cnt_q <= DT_CNT_W'(1);
      end else if (!shift_load_request_i) begin
         dt_n_q <= 1'b1;
         dt_cnt_q <= '0;
      end else if (!dt_n_q) begin
         dt_cnt_q <= dt_cnt_q + DT_CNT_W'(1);
         // Cut off early only without extend
         if (!opt.cas_extend && dt_cnt_q == DT_CNT_W'(DT_EDGES - 1)) begin
            dt_n_q <= 1'b1;
         end
      end
   end

   // Address latches; transparent mode reloads every edge
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_q <= '0;
      end else if (opt.latch_mode_bit || latch_hit) begin
         addr_q <= host_i.addr;
      end
   end

   // Outputs straight from flops
   assign row_strobe_out_n_o = row_n_q;
   assign col_strobe_out_n_o = col_n_q;
   assign refresh_status_n_o = rfs_n_q;
   assign transfer_output_enable_n_o = dt_n_q;
   assign wait_n_o = wait_n_q;
   assign latched_addr_o = addr_q;
   assign prog_word_o = prog_q;
   assign opts_o = opt;
   assign programmed_o = programmed_q;

   // Init flag is its own flop to keep the output registered
   logic init_q; // Initialization running
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         init_q <= 1'b0;
      end else begin
         init_q <= (init_cnt_q > INIT_CNT_W'(1)) |
            (prog_ev & first_pend_q & ~seq_rst);
      end
   end
   assign init_active_o = init_q;

endmodule

// File: inc/vmc_pkg.sv
// Package of the video RAM controller mode-load block.
// Assumes a single 125 MHz clock and pins already synchronous to it.
package vmc_pkg;

   // Clock period and derived cycle counts
   localparam int CLK_PERIOD_NS = 8;
   localparam int INIT_TIME_MS = 60;
   localparam int INIT_CYCLES = INIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int INIT_CNT_W = 23;
   // Row precharge time, plain default
   localparam int PRECHARGE_NS = 100;
   localparam int PRECHARGE_CYCLES = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRE_CNT_W = 4;

   // Reset sequence length in clock edges
   localparam int RESET_EDGES = 16;
   localparam int RST_CNT_W = 5;
   // Transfer enable cut-off edge count
   localparam int DT_EDGES = 4;
   localparam int DT_CNT_W = 3;

   // Widths
   localparam int ADDR_W = 22;
   localparam int PROG_W = 23;
   localparam int NCAS = 4;

   // Programming word field positions
   localparam int POS_CAS_EXTEND = 0;
   localparam int POS_LATCH_MODE = 1;
   localparam int POS_ACCESS_MODE = 2;
   localparam int POS_WRITE_CAS_DELAY = 11;
   // Programming word reset value
   localparam logic [PROG_W-1:0] PROG_RESET = 23'h000000;

   // Decoded options
   typedef struct packed {
      logic cas_extend;
      logic access_mode_bit;
      logic latch_mode_bit;
      logic write_cas_delay_bit;
   } vmc_opts_t;

   // Host-side pins of port A and programming
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic mode_load_n;
      logic refresh_disable_n;
      logic chip_sel_n;
      logic access_request_n;
      logic addr_strobe_n;
      logic ale;
      logic [NCAS-1:0] cas_extend_in_n;
   } vmc_host_t;

   // Reset sequence states
   typedef enum logic [2:0] {
      RS_IDLE = 3'b001,
      RS_HELD = 3'b010,
      RS_ARMED = 3'b100
   } vmc_rs_state_t;

   // Port A access states
   typedef enum logic [2:0] {
      AC_IDLE = 3'b001,
      AC_PEND = 3'b010,
      AC_ROW = 3'b100
   } vmc_ac_state_t;

endpackage

// File: verilog/vmc_reset_seq.sv
// Detector of the external reset and release-order sequence.
// Assumes mode load and refresh disable are synchronous, active low.
`timescale 1ns/1ps
module vmc_reset_seq
   import vmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic mode_load_n_i,
   input wire logic refresh_disable_n_i,
   output logic busy_o,
   output logic ext_reset_o,
   output logic program_o
);

   vmc_rs_state_t state_q; // Sequence state
   logic [RST_CNT_W-1:0] cnt_q; // Edges with both pins low
   logic both_low; // Both pins asserted

   assign both_low = ~mode_load_n_i & ~refresh_disable_n_i;
   // Count reaches its last edge while both still held
   assign ext_reset_o = (state_q == RS_IDLE) & both_low &
      (cnt_q == RST_CNT_W'(RESET_EDGES - 1));
   // Mode load released after refresh disable already released
   assign program_o = (state_q == RS_ARMED) & mode_load_n_i;
   // Normal mode-load programming is suppressed while busy
   assign busy_o = (state_q != RS_IDLE);

   // Consecutive edge counter; any break starts over
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
      end else if (both_low && state_q == RS_IDLE && !ext_reset_o) begin
         cnt_q <= cnt_q + RST_CNT_W'(1);
      end else begin
         cnt_q <= '0;
      end
   end

   // Release order tracking
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= RS_IDLE;
      end else begin
         case (state_q)
            RS_IDLE: begin
               if (ext_reset_o) begin
                  state_q <= RS_HELD;
               end
            end
            RS_HELD: begin
               // Mode load first or together: no programming
               if (mode_load_n_i) begin
                  state_q <= RS_IDLE;
               end else if (refresh_disable_n_i) begin
                  state_q <= RS_ARMED;
               end
            end
            RS_ARMED: begin
               if (mode_load_n_i) begin
                  state_q <= RS_IDLE;
               end
            end
            default: begin
               state_q <= RS_IDLE;
            end
         endcase
      end
   end

endmodule

// File: bench/vmc_mode_load_properties.sv
// Concurrent checks on the ports of the mode-load block.
// Assumes it is bound to vmc_mode_load with host pins synchronous to clk_i.
`timescale 1ns/1ps
module vmc_mode_load_properties
   import vmc_pkg::*;
#(
   parameter int unsigned INIT_CYCLES_P = INIT_CYCLES
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire vmc_host_t host_i,
   input wire logic refresh_busy_i,
   input wire logic refresh_req_i,
   input wire logic shift_load_request_i,
   input wire logic row_strobe_out_n_o,
   input wire logic [NCAS-1:0] col_strobe_out_n_o,
   input wire logic refresh_status_n_o,
   input wire logic transfer_output_enable_n_o,
   input wire logic wait_n_o,
   input wire logic [PROG_W-1:0] prog_word_o,
   input wire vmc_opts_t opts_o,
   input wire logic programmed_o,
   input wire logic init_active_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Edges with load and refresh disable both low; saturates so a long hold never wraps
   logic [4:0] hold_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_q <= 5'h00;
      end else if (!host_i.mode_load_n && !host_i.refresh_disable_n) begin
         hold_q <= (hold_q == 5'h1F) ? hold_q : hold_q + 5'h01;
      end else begin
         hold_q <= 5'h00;
      end
   end

   property p_word; $rose(host_i.mode_load_n) && $past(host_i.refresh_disable_n)
      |=> prog_word_o == {$past(host_i.addr), $past(host_i.cas_extend_in_n[0])}; endproperty
   a_word: assert property (p_word) else $error("word not loaded on release");
   property p_seq_clear; hold_q == 5'h0F && !host_i.mode_load_n && !host_i.refresh_disable_n
      |=> !programmed_o && prog_word_o == PROG_RESET; endproperty
   a_seq_clear: assert property (p_seq_clear) else $error("hold did not clear");
   property p_no_prog; hold_q >= 5'h10 && host_i.mode_load_n |=> !programmed_o; endproperty
   a_no_prog: assert property (p_no_prog) else $error("programmed on early load release");
   property p_init_rise; $rose(programmed_o) |=> init_active_o; endproperty
   a_init_rise: assert property (p_init_rise) else $error("no init after first load");
   property p_no_reinit; $past(programmed_o) && programmed_o && !init_active_o |=> !init_active_o; endproperty
   a_no_reinit: assert property (p_no_reinit) else $error("init entered again");
   property p_cols_end; !opts_o.cas_extend && $rose(row_strobe_out_n_o) |-> &col_strobe_out_n_o; endproperty
   a_cols_end: assert property (p_cols_end) else $error("column outlived row");
   property p_col_follow; opts_o.cas_extend && host_i.cas_extend_in_n[0] |=> col_strobe_out_n_o[0]; endproperty
   a_col_follow: assert property (p_col_follow) else $error("column ignored extend input");
   property p_rf_pin; 1'b1 |=> refresh_status_n_o == ($past(opts_o.cas_extend) ? !$past(refresh_req_i)
      : !($past(refresh_busy_i) || $past(init_active_o))); endproperty
   a_rf_pin: assert property (p_rf_pin) else $error("refresh pin wrong");
   property p_toe_four; ($rose(shift_load_request_i) && !opts_o.cas_extend) ##1 shift_load_request_i [*3]
      |=> transfer_output_enable_n_o; endproperty
   a_toe_four: assert property (p_toe_four) else $error("transfer enable past fourth edge");
   property p_row; host_i.mode_load_n && !host_i.access_request_n && programmed_o
      && (opts_o.access_mode_bit ? !host_i.addr_strobe_n : host_i.ale)
      |=> !row_strobe_out_n_o || !wait_n_o; endproperty
   a_row: assert property (p_row) else $error("access start not answered");
   property p_ml_block; !host_i.mode_load_n && row_strobe_out_n_o |=> row_strobe_out_n_o; endproperty
   a_ml_block: assert property (p_ml_block) else $error("row started under load");

   // Main scenarios reached
   c_seq_prog: cover property (hold_q >= 5'h10 && !host_i.mode_load_n && host_i.refresh_disable_n);
   c_row: cover property ($fell(row_strobe_out_n_o));
   c_toe: cover property ($rose(transfer_output_enable_n_o) && shift_load_request_i);
endmodule

// File: bench/vmc_host_model.sv
// Host bus and glue logic model driving the programming and port A pins.
// Assumes its tasks are called from one process just after a clock edge.
`timescale 1ns/1ps
module vmc_host_model
   import vmc_pkg::*;
(
   input wire logic clk_i,
   output vmc_host_t host_o
);
   // Idle bus, all strobes negated
   initial begin
      host_o = {22'h000000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 4'hF};
   end

   // Wait edges, then the usual drive delay
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Load the word by release; optional 18-edge hold, rd_first picks the release order
   task automatic load(input logic [21:0] a, input logic e, input logic seq, input logic rd_first);
      host_o.addr = a;
      host_o.cas_extend_in_n[0] = e;
      host_o.mode_load_n = 1'b0;
      host_o.refresh_disable_n = !seq;
      tick(seq ? RESET_EDGES + 2 : 2);
      host_o.refresh_disable_n = 1'b1;
      if (seq && rd_first) begin
         tick(1);
      end
      host_o.mode_load_n = 1'b1;
      tick(1);
      // Released bus no longer shows the word
      host_o.addr = ~a;
      host_o.cas_extend_in_n[0] = 1'b1;
   endtask

   // Chip-selected access under load, load released afterwards
   task automatic cs_load(input logic [21:0] a, input logic e);
      host_o.addr = a;
      host_o.cas_extend_in_n[0] = e;
      host_o.mode_load_n = 1'b0;
      tick(1);
      host_o.chip_sel_n = 1'b0;
      host_o.access_request_n = 1'b0;
      tick(1);
      host_o.access_request_n = 1'b1;
      host_o.chip_sel_n = 1'b1;
      tick(1);
      host_o.mode_load_n = 1'b1;
      tick(1);
      host_o.addr = ~a;
      host_o.cas_extend_in_n[0] = 1'b1;
   endtask

   // Port A start: one-cycle latch pulse or strobe, then extend input 0 low
   task automatic access_start(input logic mode1);
      host_o.ale = !mode1;
      host_o.addr_strobe_n = !mode1;
      host_o.access_request_n = 1'b0;
      tick(1);
      host_o.ale = 1'b0;
      host_o.addr_strobe_n = 1'b1;
      host_o.cas_extend_in_n[0] = 1'b0;
   endtask

   // Request released; extend input left low until cas_off
   task automatic access_end();
      host_o.access_request_n = 1'b1;
      tick(1);
   endtask

   task automatic cas_off();
      host_o.cas_extend_in_n = 4'hF;
      tick(1);
   endtask
endmodule

// File: bench/testbench.sv
// Self-checking bench of the mode-load block with a host model.
// Assumes the package constants and a shortened init period of 50 cycles.
`timescale 1ns/1ps
`define CHECK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end
module testbench
   import vmc_pkg::*;
;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic refresh_busy_i = 1'b0;
   logic refresh_req_i = 1'b0;
   logic shift_load_request_i = 1'b0;
   // Port B capture and refresh engine strobes, idle until their scenarios
   logic portb_req_n = 1'b1, portb_grant = 1'b0, scrub_refresh_i = 1'b0, refresh_row_i = 1'b0;
   vmc_host_t host_w;
   logic row_n, rf_n, toe_n, wait_n, programmed, init_act;
   logic [NCAS-1:0] col_n;
   logic [ADDR_W-1:0] latched;
   logic [PROG_W-1:0] word;
   vmc_opts_t opts;
   int error_cnt = 0;
   int total_checks = 0;
   int n;
   // Words: low two bits are latch and access mode
   localparam logic [21:0] W0 = 22'h15A5A0;
   localparam logic [21:0] W1 = 22'h2C3C3F;

   always #4 clk_i = ~clk_i;

   vmc_host_model host (.clk_i(clk_i), .host_o(host_w));
   // Port B and refresh engine strobes come from the bench so their decode is exercised
   vmc_mode_load #(.INIT_CYCLES_P(50)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_i(host_w),
      .portb_access_request_n_i(portb_req_n), .portb_grant_i(portb_grant), .refresh_busy_i(refresh_busy_i),
      .refresh_req_i(refresh_req_i), .scrub_refresh_i(scrub_refresh_i), .refresh_row_i(refresh_row_i),
      .shift_load_request_i(shift_load_request_i), .row_strobe_out_n_o(row_n), .col_strobe_out_n_o(col_n),
      .refresh_status_n_o(rf_n), .transfer_output_enable_n_o(toe_n), .wait_n_o(wait_n),
      .latched_addr_o(latched), .prog_word_o(word), .opts_o(opts), .programmed_o(programmed),
      .init_active_o(init_act));

   task automatic stop_test();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Bounded wait for the row strobe, precharge or init may insert waits
   task automatic wait_row();
      n = 0;
      while (row_n !== 1'b0 && n < 200) begin
         host.tick(1);
         n++;
      end
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      `CHECK({word, programmed, row_n, wait_n, rf_n}, {23'h000000, 4'h7})
      host.load(W0, 1'b0, 1'b1, 1'b1);
      `CHECK({word, programmed}, {W0, 1'b0, 1'b1})
      host.tick(1);
      `CHECK({init_act, rf_n}, 2'h2)
      n = 0;
      while (init_act !== 1'b0 && n < 200) begin
         host.tick(1);
         n++;
      end
      host.tick(20);
      // Mode 0, address latched on the pulse, extend off
      host.access_start(1'b0);
      wait_row();
      host.tick(2);
      `CHECK({row_n, col_n, latched}, {1'b0, 4'hE, ~W0})
      host.access_end();
      `CHECK({row_n, col_n}, 5'h1F)
      host.cas_off();
      // Transfer enable cut at the fourth edge
      shift_load_request_i = 1'b1;
      host.tick(2);
      `CHECK(toe_n, 1'b0)
      host.tick(2);
      `CHECK(toe_n, 1'b1)
      shift_load_request_i = 1'b0;
      host.load(W1, 1'b1, 1'b0, 1'b0);
      host.tick(1);
      `CHECK({word, init_act, opts}, {W1, 1'b1, 1'b0, 4'hF})
      host.tick(20);
      // Mode 1, transparent latch, extend on
      host.access_start(1'b1);
      wait_row();
      host.tick(2);
      `CHECK({row_n, latched}, {1'b0, ~W1})
      host.access_end();
      `CHECK({row_n, col_n}, 5'h1E)
      host.cas_off();
      `CHECK(col_n, 4'hF)
      refresh_req_i = 1'b1;
      host.tick(1);
      `CHECK(rf_n, 1'b0)
      refresh_req_i = 1'b0;
      refresh_busy_i = 1'b1;
      shift_load_request_i = 1'b1;
      host.tick(6);
      `CHECK({rf_n, toe_n}, 2'h2)
      shift_load_request_i = 1'b0;
      refresh_busy_i = 1'b0;
      host.tick(1);
      `CHECK(toe_n, 1'b1)
      host.cs_load(22'h0F0F00, 1'b0);
      `CHECK({word, init_act}, {22'h0F0F00, 2'h0})
      // Latch mode 0: port B request alone must not capture, grant does
      portb_req_n = 1'b0;
      host.tick(1);
      `CHECK(latched, 22'h0F0F00)
      portb_grant = 1'b1;
      host.tick(1);
      `CHECK(latched, 22'h30F0FF)
      {portb_req_n, portb_grant} = 2'h2;
      // Extend off: busy shows on the status pin; plain refresh row leaves columns off
      refresh_busy_i = 1'b1;
      refresh_row_i = 1'b1;
      host.tick(1);
      `CHECK({rf_n, row_n, col_n}, 6'h0F)
      // Scrubbing drives all columns with the row, extend inputs negated
      scrub_refresh_i = 1'b1;
      host.tick(1);
      `CHECK({rf_n, row_n, col_n}, 6'h00)
      {refresh_busy_i, refresh_row_i, scrub_refresh_i} = 3'h0;
      host.tick(1);
      `CHECK({rf_n, row_n, col_n}, 6'h3F)
      host.load(W1, 1'b0, 1'b1, 1'b0);
      `CHECK({word, programmed}, 24'h000000)
      // One edge apart so the bus is not driven twice in a time step
      host.tick(1);
      host.load(W0, 1'b0, 1'b1, 1'b1);
      host.tick(1);
      `CHECK({word, init_act}, {W0, 2'h1})
      // Access during initialization is held by wait states, then runs
      host.access_start(1'b0);
      `CHECK({row_n, wait_n}, 2'h2)
      wait_row();
      `CHECK({row_n, wait_n}, 2'h1)
      stop_test();
   end

   // Watchdog well beyond the roughly 270 cycles of the sequence
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      stop_test();
   end
endmodule

bind vmc_mode_load vmc_mode_load_properties #(.INIT_CYCLES_P(INIT_CYCLES_P)) u_props (.clk_i(clk_i),
   .sys_rst_i(sys_rst_i), .host_i(host_i), .refresh_busy_i(refresh_busy_i), .refresh_req_i(refresh_req_i),
   .shift_load_request_i(shift_load_request_i), .row_strobe_out_n_o(row_strobe_out_n_o),
   .col_strobe_out_n_o(col_strobe_out_n_o), .refresh_status_n_o(refresh_status_n_o),
   .transfer_output_enable_n_o(transfer_output_enable_n_o), .wait_n_o(wait_n_o),
   .prog_word_o(prog_word_o), .opts_o(opts_o), .programmed_o(programmed_o), .init_active_o(init_active_o));
